// *** rtl/outbound_window_pm.sv ***
// outbound address translation windows and endpoint power management
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module outbound_window_pm #(
  parameter int unsigned RST_CYC = 16
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // system bus master requests
  input  wire logic        BUS_REQ_IN,
  input  wire logic        BUS_WR_IN,
  input  wire logic [31:0] BUS_ADDR_IN,
  output logic             BUS_ACK_OUT,
  output logic             BUS_MISS_OUT,
  output logic             BUS_RVALID_OUT,
  // frame dma engine requests
  input  wire logic        DMA_REQ_IN,
  input  wire logic        DMA_WR_IN,
  input  wire logic [31:0] DMA_ADDR_IN,
  output logic             DMA_ACK_OUT,
  output logic             DMA_MISS_OUT,
  output logic             DMA_RVALID_OUT,
  // shared read data back to the masters
  output logic      [31:0] RDATA_OUT,
  // outbound request header to the link
  output logic             TLP_VALID_OUT,
  output logic             TLP_WR_OUT,
  output logic             TLP_SRC_OUT,
  output logic      [63:0] TLP_ADDR_OUT,
  output logic             TLP_ADDR64_OUT,
  output logic      [1:0]  TLP_ATTR_OUT,
  output logic             TLP_TD_OUT,
  output logic      [2:0]  TLP_TC_OUT,
  output logic      [4:0]  TLP_TYPE_OUT,
  output logic             TLP_EP_OUT,
  output logic      [3:0]  TLP_BE_OUT,
  output logic      [7:0]  TLP_MSG_OUT,
  // completions from the link
  input  wire logic        CPL_VALID_IN,
  input  wire logic        CPL_SRC_IN,
  input  wire logic [31:0] CPL_DATA_IN,
  // power management
  input  wire logic [1:0]  POWER_STATE_FIELD_IN,
  input  wire logic        PME_EN_IN,
  input  wire logic [1:0]  OB_IRQ_IN,
  output logic             PME_OUT,
  output logic             IRQ_OUT,
  output logic             BEACON_OUT,
  output logic             WAKE_OUT,
  output logic             WAKE_OE_OUT,
  output logic             AUX_PWR_DET_OUT,
  output logic             CHIP_RST_OUT
);
  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  logic        idx_q;
  logic [10:0] cfg1_q   [2];
  logic [7:0]  msg_q    [2];
  logic [1:0]  ena_q;
  logic [15:0] base_q   [2];
  logic [15:0] limit_q  [2];
  logic [15:0] tlo_q    [2];
  logic [31:0] thi_q    [2];
  logic        bsel_q;
  logic        bep_q;
  logic [3:0]  bbe_q;
  logic        dsel_q;
  logic        evt_q;
  logic        evt_en_q;
  logic [3:0]  pmcfg_q;
  logic [1:0]  aux_q;
  logic [1:0]  pm_prev_q;
  logic [1:0]  obi_prev_q;
  logic        wake_act_q;
  logic [15:0] rst_cnt_q;
  logic [31:0] rdata_d;
  logic        mapped;
  logic        acc;
  logic        wr;
  // --------------------------------------------------------------------
  // apb slave: one wait state, write at the pready edge
  // --------------------------------------------------------------------
  assign acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;
  assign wr  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;

  always_comb begin
    mapped  = 1'b1;
    rdata_d = owp_pkg::ZERO32;
    case (PADDR_IN)
      owp_pkg::A_REGION_SEL: rdata_d[0] = idx_q;
      owp_pkg::A_CFG1:       rdata_d[10:0] = cfg1_q[idx_q];
      owp_pkg::A_CFG2:       rdata_d = {ena_q[idx_q], 23'h00_0000, msg_q[idx_q]};
      owp_pkg::A_BASE:       rdata_d[15:0] = base_q[idx_q];
      owp_pkg::A_LIMIT:      rdata_d[15:0] = limit_q[idx_q];
      owp_pkg::A_TGT_LO:     rdata_d[15:0] = tlo_q[idx_q];
      owp_pkg::A_TGT_HI:     rdata_d = thi_q[idx_q];
      owp_pkg::A_BUS_CFG:    rdata_d[5:0] = {bbe_q, bep_q, bsel_q};
      owp_pkg::A_DMA_CFG:    rdata_d[0] = dsel_q;
      owp_pkg::A_PM_STAT:    rdata_d[1:0] = pm_prev_q;
      owp_pkg::A_PM_EVT:     rdata_d[0] = evt_q;
      owp_pkg::A_PM_EVT_EN:  rdata_d[0] = evt_en_q;
      owp_pkg::A_IRQ_ID:     rdata_d[0] = IRQ_OUT;
      owp_pkg::A_PM_CFG:     rdata_d[3:0] = pmcfg_q;
      owp_pkg::A_AUX:        rdata_d[1:0] = aux_q;
      owp_pkg::A_SOFT_RST:   rdata_d[0] = CHIP_RST_OUT;
      default:               mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= owp_pkg::ZERO32;
    end else begin
      PREADY_OUT  <= acc;
      PSLVERR_OUT <= acc && !mapped;
      PRDATA_OUT  <= (acc && !PWRITE_IN) ? rdata_d : owp_pkg::ZERO32;
    end
  end

  // region fields are edited through the index, so software must select first
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      idx_q   <= 1'b0;
      ena_q   <= 2'h0;
      bsel_q  <= 1'b0;
      bep_q   <= 1'b0;
      bbe_q   <= owp_pkg::BE_ALL;
      dsel_q  <= 1'b0;
      pmcfg_q <= 4'h0;
      aux_q   <= 2'h0;
      evt_en_q <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        cfg1_q[i]  <= 11'h000;
        msg_q[i]   <= 8'h00;
        base_q[i]  <= 16'h0000;
        limit_q[i] <= 16'h0000;
        tlo_q[i]   <= 16'h0000;
        thi_q[i]   <= owp_pkg::ZERO32;
      end
    end else if (wr) begin
      case (PADDR_IN)
        owp_pkg::A_REGION_SEL: idx_q <= PWDATA_IN[0];
        owp_pkg::A_CFG1:       cfg1_q[idx_q] <= PWDATA_IN[10:0];
        owp_pkg::A_CFG2: begin
          msg_q[idx_q] <= PWDATA_IN[owp_pkg::F_MSG +: 8];
          ena_q[idx_q] <= PWDATA_IN[owp_pkg::F_ENA];
        end
        owp_pkg::A_BASE:       base_q[idx_q] <= PWDATA_IN[15:0];
        owp_pkg::A_LIMIT:      limit_q[idx_q] <= PWDATA_IN[15:0];
        owp_pkg::A_TGT_LO:     tlo_q[idx_q] <= PWDATA_IN[15:0];
        owp_pkg::A_TGT_HI:     thi_q[idx_q] <= PWDATA_IN;
        owp_pkg::A_BUS_CFG: begin
          bsel_q <= PWDATA_IN[owp_pkg::F_SEL];
          bep_q  <= PWDATA_IN[owp_pkg::F_EP];
          bbe_q  <= PWDATA_IN[owp_pkg::F_BE +: 4];
        end
        owp_pkg::A_DMA_CFG:    dsel_q <= PWDATA_IN[owp_pkg::F_SEL];
        owp_pkg::A_PM_EVT_EN:  evt_en_q <= PWDATA_IN[0];
        owp_pkg::A_PM_CFG:     pmcfg_q <= PWDATA_IN[3:0];
        owp_pkg::A_AUX:        aux_q <= PWDATA_IN[1:0];
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // outbound translation
  // --------------------------------------------------------------------
  logic        take_bus, take_dma, take, r, hit;
  logic [31:0] addr;
  logic [15:0] key;
  logic [63:0] xaddr;
  assign take_bus = BUS_REQ_IN && !BUS_ACK_OUT;
  assign take_dma = DMA_REQ_IN && !DMA_ACK_OUT && !take_bus;
  assign take     = take_bus || take_dma;
  assign addr     = take_bus ? BUS_ADDR_IN : DMA_ADDR_IN;
  assign r        = take_bus ? bsel_q : dsel_q;
  assign key      = {1'b0, r, addr[29:16]};
  assign hit      = (addr[31:30] == owp_pkg::DMA_REGION_TOP) && ena_q[r]
                    && key >= base_q[r] && key <= limit_q[r];
  assign xaddr    = {thi_q[r], tlo_q[r], owp_pkg::ADDR_LO_ZERO}
                    + {34'h0_0000_0000, addr[29:0]};

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      BUS_ACK_OUT    <= 1'b0;
      DMA_ACK_OUT    <= 1'b0;
      BUS_MISS_OUT   <= 1'b0;
      DMA_MISS_OUT   <= 1'b0;
      TLP_VALID_OUT  <= 1'b0;
      TLP_WR_OUT     <= 1'b0;
      TLP_SRC_OUT    <= 1'b0;
      TLP_ADDR_OUT   <= 64'h0000_0000_0000_0000;
      TLP_ADDR64_OUT <= 1'b0;
      TLP_ATTR_OUT   <= 2'h0;
      TLP_TD_OUT     <= 1'b0;
      TLP_TC_OUT     <= 3'h0;
      TLP_TYPE_OUT   <= 5'h00;
      TLP_EP_OUT     <= 1'b0;
      TLP_BE_OUT     <= 4'h0;
      TLP_MSG_OUT    <= 8'h00;
    end else begin
      BUS_ACK_OUT   <= take_bus;
      DMA_ACK_OUT   <= take_dma;
      BUS_MISS_OUT  <= take_bus && !hit;
      DMA_MISS_OUT  <= take_dma && !hit;
      TLP_VALID_OUT <= take && hit;
      if (take && hit) begin
        TLP_WR_OUT     <= take_bus ? BUS_WR_IN : DMA_WR_IN;
        TLP_SRC_OUT    <= take_dma;
        TLP_ADDR_OUT   <= xaddr;
        TLP_ADDR64_OUT <= thi_q[r] != owp_pkg::ZERO32;
        TLP_ATTR_OUT   <= cfg1_q[r][owp_pkg::F_ATTR +: 2];
        TLP_TD_OUT     <= cfg1_q[r][owp_pkg::F_TD];
        TLP_TC_OUT     <= cfg1_q[r][owp_pkg::F_TC +: 3];
        TLP_TYPE_OUT   <= cfg1_q[r][owp_pkg::F_TYPE +: 5];
        TLP_MSG_OUT    <= msg_q[r];
        TLP_EP_OUT     <= take_bus && bep_q;
        TLP_BE_OUT     <= take_bus ? bbe_q : owp_pkg::BE_ALL;
      end
    end
  end

  // completions routed by the tag the link hands back
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      BUS_RVALID_OUT <= 1'b0;
      DMA_RVALID_OUT <= 1'b0;
      RDATA_OUT      <= owp_pkg::ZERO32;
    end else begin
      BUS_RVALID_OUT <= CPL_VALID_IN && !CPL_SRC_IN;
      DMA_RVALID_OUT <= CPL_VALID_IN && CPL_SRC_IN;
      if (CPL_VALID_IN) begin
        RDATA_OUT <= CPL_DATA_IN;
      end
    end
  end
  // --------------------------------------------------------------------
  // power management
  // --------------------------------------------------------------------
  logic pm_chg, obi_chg, pme_ok, pme_trig, evt_clr;
  assign pm_chg   = POWER_STATE_FIELD_IN != pm_prev_q;
  assign obi_chg  = OB_IRQ_IN != obi_prev_q;
  assign pme_ok   = PME_EN_IN && POWER_STATE_FIELD_IN != owp_pkg::PS_D0;
  assign pme_trig = pme_ok && ((take && hit)
                    || (obi_chg && !pmcfg_q[owp_pkg::F_WDIS]));
  assign evt_clr  = wr && PADDR_IN == owp_pkg::A_PM_EVT && PWDATA_IN[0];

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pm_prev_q  <= owp_pkg::PS_D0;
      obi_prev_q <= 2'h0;
      evt_q      <= 1'b0;
      IRQ_OUT    <= 1'b0;
      PME_OUT    <= 1'b0;
    end else begin
      pm_prev_q  <= POWER_STATE_FIELD_IN;
      obi_prev_q <= OB_IRQ_IN;
      // a change in the clearing cycle still lands
      evt_q      <= pm_chg || (evt_q && !evt_clr);
      IRQ_OUT    <= evt_q && evt_en_q;
      PME_OUT    <= pme_trig;
    end
  end

  // wake holds until the link leaves D3
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wake_act_q      <= 1'b0;
      BEACON_OUT      <= 1'b0;
      WAKE_OUT        <= 1'b0;
      WAKE_OE_OUT     <= 1'b0;
      AUX_PWR_DET_OUT <= 1'b0;
    end else begin
      wake_act_q <= (pme_trig && POWER_STATE_FIELD_IN == owp_pkg::PS_D3 && pmcfg_q[owp_pkg::F_BDIS])
                    || (wake_act_q && POWER_STATE_FIELD_IN == owp_pkg::PS_D3);
      BEACON_OUT <= POWER_STATE_FIELD_IN == owp_pkg::PS_D3 && !pmcfg_q[owp_pkg::F_BDIS];
      WAKE_OUT   <= wake_act_q ~^ pmcfg_q[owp_pkg::F_WPOL];
      WAKE_OE_OUT <= pmcfg_q[owp_pkg::F_BDIS]
                     && (!pmcfg_q[owp_pkg::F_WOE] || wake_act_q);
      AUX_PWR_DET_OUT <= aux_q == owp_pkg::AUX_FORCE;
    end
  end

  // chip reset pulse; no link reset input exists here, so link resets
  // cannot disturb this state
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_cnt_q    <= 16'h0000;
      CHIP_RST_OUT <= 1'b0;
    end else begin
      if (wr && PADDR_IN == owp_pkg::A_SOFT_RST && PWDATA_IN[0]) begin
        rst_cnt_q <= RST_CYC[15:0];
      end else if (rst_cnt_q != 16'h0000) begin
        rst_cnt_q <= rst_cnt_q - 16'h0001;
      end
      CHIP_RST_OUT <= rst_cnt_q != 16'h0000;
    end
  end
  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  AST_MISS_NO_REQ: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (take_bus && !hit) |=> (BUS_MISS_OUT && !TLP_VALID_OUT))
    else $error("unmatched bus access issued a request");
  AST_ADDR64: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    TLP_VALID_OUT |-> (TLP_ADDR64_OUT == (TLP_ADDR_OUT[63:32] != 32'h0000_0000)))
    else $error("address width flag disagrees with upper address");
  AST_DMA_RANGE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (take_dma && DMA_ADDR_IN[31:30] != 2'h3) |=> !TLP_VALID_OUT && DMA_MISS_OUT)
    else $error("dma access below window translated");
  AST_XLATE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (take && hit) |=> TLP_ADDR_OUT[15:0] == $past(addr[15:0]))
    else $error("low address bits altered by translation");
  AST_PM_EVT: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    pm_chg |=> evt_q ##1 (IRQ_OUT == evt_en_q || $past(evt_en_q) != evt_en_q))
    else $error("state change lost or interrupt wrong");
  AST_PME_COND: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    PME_OUT |-> $past(PME_EN_IN) && $past(POWER_STATE_FIELD_IN) != 2'h0)
    else $error("power event outside allowed state");
  AST_BEACON: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (POWER_STATE_FIELD_IN == 2'h3 && !pmcfg_q[0]) |=> BEACON_OUT)
    else $error("beacon missing in D3");
  AST_AUX: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (wr && PADDR_IN == 8'h38 && PWDATA_IN[1:0] == 2'h3) |=> ##1 AUX_PWR_DET_OUT)
    else $error("aux detect not forced");
  AST_SOFT_RST: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (wr && PADDR_IN == 8'h3C && PWDATA_IN[0]) |=> ##1 CHIP_RST_OUT[*3])
    else $error("chip reset pulse missing");
  AST_CPL_ROUTE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    (CPL_VALID_IN && !CPL_SRC_IN) |=> BUS_RVALID_OUT && !DMA_RVALID_OUT)
    else $error("completion sent to wrong master");
endmodule
`default_nettype wire

// *** shared/owp_pkg.sv ***
// constants of the outbound window and power-management block
package owp_pkg;
  // --------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_REGION_SEL = 8'h00;
  localparam logic [7:0] A_CFG1       = 8'h04;
  localparam logic [7:0] A_CFG2       = 8'h08;
  localparam logic [7:0] A_BASE       = 8'h0C;
  localparam logic [7:0] A_LIMIT      = 8'h10;
  localparam logic [7:0] A_TGT_LO     = 8'h14;
  localparam logic [7:0] A_TGT_HI     = 8'h18;
  localparam logic [7:0] A_BUS_CFG    = 8'h1C;
  localparam logic [7:0] A_DMA_CFG    = 8'h20;
  localparam logic [7:0] A_PM_STAT    = 8'h24;
  localparam logic [7:0] A_PM_EVT     = 8'h28;
  localparam logic [7:0] A_PM_EVT_EN  = 8'h2C;
  localparam logic [7:0] A_IRQ_ID     = 8'h30;
  localparam logic [7:0] A_PM_CFG     = 8'h34;
  localparam logic [7:0] A_AUX        = 8'h38;
  localparam logic [7:0] A_SOFT_RST   = 8'h3C;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int unsigned F_TYPE = 0;
  localparam int unsigned F_TC   = 5;
  localparam int unsigned F_TD   = 8;
  localparam int unsigned F_ATTR = 9;
  localparam int unsigned F_MSG  = 0;
  localparam int unsigned F_ENA  = 31;
  localparam int unsigned F_SEL  = 0;
  localparam int unsigned F_EP   = 1;
  localparam int unsigned F_BE   = 2;
  localparam int unsigned F_BDIS = 0;
  localparam int unsigned F_WPOL = 1;
  localparam int unsigned F_WOE  = 2;
  localparam int unsigned F_WDIS = 3;
  // --------------------------------------------------------------------
  // encodings and reset values
  // --------------------------------------------------------------------
  localparam logic [1:0]  DMA_REGION_TOP = 2'h3;
  localparam logic [1:0]  AUX_FORCE      = 2'h3;
  localparam logic [1:0]  PS_D0          = 2'h0;
  localparam logic [1:0]  PS_D3          = 2'h3;
  localparam logic [3:0]  BE_ALL         = 4'hF;
  localparam logic [15:0] ADDR_LO_ZERO   = 16'h0000;
  localparam logic [31:0] ZERO32         = 32'h0000_0000;
endpackage

// *** tb/outbound_window_pm_tb.sv ***
// self-checking bench for the outbound window and power-management block
`timescale 1ns/1ps
`default_nettype none
module outbound_window_pm_tb;
  typedef struct packed {logic src; logic wr; logic [31:0] addr; logic miss;} row_t;
  localparam int unsigned RST_CYC = 4;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, slow, got_miss, got_vld, err_q;
  logic        bus_req, bus_wr, bus_ack, bus_miss, bus_rv, dma_req, dma_wr, dma_ack, dma_miss;
  logic        dma_rv, tlp_v, tlp_wr, tlp_src, tlp_a64, tlp_td, tlp_ep, cpl_v, cpl_src;
  logic        pme_en, pme, irq, beacon, wake, wake_oe, aux, chip_rst;
  logic [1:0]  tlp_attr, power_state_field, ob_irq;
  logic [2:0]  tlp_tc;
  logic [3:0]  tlp_be;
  logic [4:0]  tlp_type;
  logic [7:0]  paddr, tlp_msg;
  logic [17:0] hdr_got;
  logic [31:0] pwdata, prdata, rdata, cpl_data, rd_q, bus_addr, dma_addr, saved;
  logic [63:0] tlp_addr, ea;
  logic [31:0] hi_v [2];
  logic [15:0] lo_v [2];
  logic [15:0] hdr_v [2];
  row_t        rows [6];
  int          miscompares, n_compared, pme_cnt, rst_cnt;
  assign hdr_got = {tlp_wr, tlp_src, tlp_attr, tlp_td, tlp_tc, tlp_type, tlp_ep, tlp_be};
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (pme === 1'b1) pme_cnt++;
    if (chip_rst === 1'b1) rst_cnt++;
  end
  outbound_window_pm #(.RST_CYC(RST_CYC)) outbound_window_pm_i (
    .CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BUS_REQ_IN(bus_req), .BUS_WR_IN(bus_wr),
    .BUS_ADDR_IN(bus_addr), .BUS_ACK_OUT(bus_ack), .BUS_MISS_OUT(bus_miss),
    .BUS_RVALID_OUT(bus_rv), .DMA_REQ_IN(dma_req), .DMA_WR_IN(dma_wr),
    .DMA_ADDR_IN(dma_addr), .DMA_ACK_OUT(dma_ack), .DMA_MISS_OUT(dma_miss),
    .DMA_RVALID_OUT(dma_rv), .RDATA_OUT(rdata), .TLP_VALID_OUT(tlp_v), .TLP_WR_OUT(tlp_wr),
    .TLP_SRC_OUT(tlp_src), .TLP_ADDR_OUT(tlp_addr), .TLP_ADDR64_OUT(tlp_a64),
    .TLP_ATTR_OUT(tlp_attr), .TLP_TD_OUT(tlp_td), .TLP_TC_OUT(tlp_tc), .TLP_TYPE_OUT(tlp_type),
    .TLP_EP_OUT(tlp_ep), .TLP_BE_OUT(tlp_be), .TLP_MSG_OUT(tlp_msg), .CPL_VALID_IN(cpl_v),
    .CPL_SRC_IN(cpl_src), .CPL_DATA_IN(cpl_data), .POWER_STATE_FIELD_IN(power_state_field), .PME_EN_IN(pme_en),
    .OB_IRQ_IN(ob_irq), .PME_OUT(pme), .IRQ_OUT(irq), .BEACON_OUT(beacon), .WAKE_OUT(wake),
    .WAKE_OE_OUT(wake_oe), .AUX_PWR_DET_OUT(aux), .CHIP_RST_OUT(chip_rst)
  );
  root_complex_model root_complex_model_i (
    .clk_in(clk), .resetn_in(rst_n), .slow_in(slow), .tlp_valid_in(tlp_v),
    .tlp_wr_in(tlp_wr), .tlp_src_in(tlp_src), .tlp_addr_in(tlp_addr),
    .cpl_valid_out(cpl_v), .cpl_src_out(cpl_src), .cpl_data_out(cpl_data)
  );
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    results();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang();
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // the idle master sees the inverted address so a crossed path shows up
  task automatic mreq(input logic src, input logic wr, input logic [31:0] a);
    int k;
    k = 0;
    @(posedge clk);
    bus_req  <= !src;
    dma_req  <= src;
    bus_wr   <= wr;
    dma_wr   <= wr;
    bus_addr <= src ? ~a : a;
    dma_addr <= src ? a : ~a;
    do begin
      @(posedge clk);
      k++;
    end while ((src ? dma_ack : bus_ack) !== 1'b1 && k < 20);
    if ((src ? dma_ack : bus_ack) !== 1'b1) hang();
    got_miss = src ? dma_miss : bus_miss;
    got_vld  = tlp_v;
    bus_req  <= 1'b0;
    dma_req  <= 1'b0;
  endtask
  task automatic cpl_wait(input logic src, input logic [31:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bus_rv !== 1'b1 && dma_rv !== 1'b1 && k < 20);
    if (bus_rv !== 1'b1 && dma_rv !== 1'b1) hang();
    chk({bus_rv, dma_rv, rdata}, {!src, src, exp});
  endtask
  function automatic logic [63:0] exp_addr(input logic src, input logic [31:0] a);
    return {hi_v[src], lo_v[src], 16'h0000} + 64'(a[29:0]);
  endfunction
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, bus_req, bus_wr, dma_req, dma_wr, pme_en, slow} = '0;
    {paddr, pwdata, bus_addr, dma_addr, power_state_field, ob_irq} = '0;
    hi_v = '{32'h0000_0000, 32'h0000_0002};
    lo_v = '{16'hC000, 16'h0010};
    hdr_v = '{{2'h1, 1'b1, 3'h5, 5'h00, 1'b1, 4'h6}, {2'h2, 1'b0, 3'h3, 5'h00, 1'b0, 4'hF}};
    rows = '{'{1'b0, 1'b1, 32'hC000_1234, 1'b0}, '{1'b0, 1'b0, 32'hFFFF_FFFC, 1'b0},
             '{1'b1, 1'b1, 32'hC000_0000, 1'b0}, '{1'b1, 1'b0, 32'hFFFF_0010, 1'b0},
             '{1'b0, 1'b0, 32'h8000_0000, 1'b1}, '{1'b1, 1'b1, 32'h0000_0040, 1'b1}};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({pready, bus_ack, tlp_v, pme, irq, beacon, wake, wake_oe, aux, chip_rst}, 0);
    apb(1'b0, owp_pkg::A_BUS_CFG, 0);
    chk(rd_q, 32'h0000_003C);
    apb(1'b0, 8'h40, 0);
    chk({err_q, rd_q}, {1'b1, 32'h0000_0000});
    apb(1'b1, owp_pkg::A_REGION_SEL, 0);
    apb(1'b1, owp_pkg::A_BASE, 32'h0000_0000);
    apb(1'b1, owp_pkg::A_LIMIT, 32'h0000_3FFF);
    apb(1'b1, owp_pkg::A_CFG1, 32'h0000_03A0);
    apb(1'b1, owp_pkg::A_CFG2, 32'h8000_007E);
    apb(1'b1, owp_pkg::A_TGT_LO, 32'h0000_C000);
    apb(1'b1, owp_pkg::A_TGT_HI, 32'h0000_0000);
    apb(1'b1, owp_pkg::A_BUS_CFG, 32'h0000_001A);
    // dma stays idle while its window is written
    apb(1'b1, owp_pkg::A_REGION_SEL, 1);
    apb(1'b1, owp_pkg::A_BASE, 32'h0000_4000);
    apb(1'b1, owp_pkg::A_LIMIT, 32'h0000_7FFF);
    apb(1'b1, owp_pkg::A_CFG1, 32'h0000_0460);
    apb(1'b1, owp_pkg::A_CFG2, 32'h8000_0011);
    apb(1'b1, owp_pkg::A_TGT_LO, 32'h0000_0010);
    apb(1'b1, owp_pkg::A_TGT_HI, 32'h0000_0002);
    apb(1'b1, owp_pkg::A_DMA_CFG, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      mreq(rows[i].src, rows[i].wr, rows[i].addr);
      ea = exp_addr(rows[i].src, rows[i].addr);
      chk({got_miss, got_vld}, {rows[i].miss, !rows[i].miss});
      if (!rows[i].miss) begin
        chk(tlp_addr, ea);
        chk(tlp_a64, ea[63:32] != 32'h0000_0000);
        chk(hdr_got, {rows[i].wr, rows[i].src, hdr_v[rows[i].src]});
        if (!rows[i].src) chk(tlp_msg, 8'h7E);
        if (!rows[i].wr) cpl_wait(rows[i].src, ea[31:0] ^ 32'h5A5A_5A5A);
      end
    end
    apb(1'b1, owp_pkg::A_REGION_SEL, 0);
    apb(1'b1, owp_pkg::A_TGT_LO, 32'h0000_8000);
    lo_v[0] = 16'h8000;
    mreq(1'b0, 1'b0, 32'hC000_0100);
    ea = exp_addr(1'b0, 32'hC000_0100);
    chk(tlp_addr, ea);
    cpl_wait(1'b0, ea[31:0] ^ 32'h5A5A_5A5A);
    apb(1'b1, owp_pkg::A_CFG2, 32'h0000_007E);
    mreq(1'b0, 1'b1, 32'hC000_0000);
    chk({got_miss, got_vld}, 2'b10);
    power_state_field <= 2'h1;
    apb(1'b0, owp_pkg::A_PM_STAT, 0);
    chk(rd_q, 32'h0000_0001);
    power_state_field <= owp_pkg::PS_D3;
    apb(1'b1, owp_pkg::A_PM_EVT, 1);
    apb(1'b0, owp_pkg::A_PM_EVT, 0);
    chk({irq, beacon, rd_q}, {2'b01, 32'h0000_0000});
    // state change lands on the clearing edge: the set must win
    fork
      apb(1'b1, owp_pkg::A_PM_EVT, 1);
      begin
        idle(3);
        power_state_field <= 2'h1;
      end
    join
    apb(1'b0, owp_pkg::A_PM_EVT, 0);
    chk(rd_q, 32'h0000_0001);
    power_state_field <= owp_pkg::PS_D3;
    apb(1'b1, owp_pkg::A_PM_EVT_EN, 1);
    apb(1'b0, owp_pkg::A_IRQ_ID, 0);
    chk({irq, rd_q}, {1'b1, 32'h0000_0001});
    apb(1'b1, owp_pkg::A_PM_EVT, 1);
    apb(1'b0, owp_pkg::A_IRQ_ID, 0);
    chk({irq, rd_q}, 0);
    pme_cnt = 0;
    mreq(1'b1, 1'b1, 32'hC000_0000);
    idle(6);
    chk(pme_cnt, 0);
    pme_en <= 1'b1;
    pme_cnt = 0;
    mreq(1'b1, 1'b1, 32'hC000_0000);
    idle(6);
    chk(pme_cnt, 1);
    pme_cnt = 0;
    ob_irq <= 2'b01;
    idle(6);
    chk(pme_cnt, 1);
    apb(1'b1, owp_pkg::A_PM_CFG, 32'h0000_0008);
    pme_cnt = 0;
    ob_irq <= 2'b00;
    idle(6);
    chk(pme_cnt, 0);
    apb(1'b1, owp_pkg::A_PM_CFG, 32'h0000_0003);
    mreq(1'b1, 1'b1, 32'hC000_0000);
    idle(4);
    chk({beacon, wake, wake_oe}, 3'b011);
    power_state_field <= owp_pkg::PS_D0;
    idle(4);
    pme_cnt = 0;
    mreq(1'b1, 1'b1, 32'hC000_0000);
    idle(6);
    chk({wake, 32'(pme_cnt)}, 0);
    // open-drain wake releases the pin while inactive
    apb(1'b1, owp_pkg::A_PM_CFG, 32'h0000_0007);
    idle(2);
    chk({wake, wake_oe}, 2'b00);
    apb(1'b1, owp_pkg::A_AUX, 32'h0000_0003);
    idle(2);
    chk(aux, 1'b1);
    apb(1'b1, owp_pkg::A_AUX, 32'h0000_0001);
    idle(2);
    chk(aux, 1'b0);
    apb(1'b0, owp_pkg::A_BUS_CFG, 0);
    saved = rd_q;
    rst_cnt = 0;
    apb(1'b1, owp_pkg::A_SOFT_RST, 1);
    idle(RST_CYC + 4);
    chk(rst_cnt, RST_CYC);
    apb(1'b1, owp_pkg::A_BUS_CFG, saved);
    results();
  end
endmodule
`default_nettype wire

// *** tb/root_complex_model.sv ***
// behavioural root complex answering outbound reads with completions
`timescale 1ns/1ps
`default_nettype none
module root_complex_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // answer pace and outbound requests
  input  wire logic        slow_in,
  input  wire logic        tlp_valid_in,
  input  wire logic        tlp_wr_in,
  input  wire logic        tlp_src_in,
  input  wire logic [63:0] tlp_addr_in,
  // completions
  output logic             cpl_valid_out,
  output logic             cpl_src_out,
  output logic      [31:0] cpl_data_out
);
  logic [3:0]  wait_q;
  logic [31:0] data_q;
  // inverse data outside a completion, so a stale value never matches
  assign cpl_data_out = cpl_valid_out ? data_q : ~data_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q        <= 4'h0;
      data_q        <= 32'h0000_0000;
      cpl_src_out   <= 1'b0;
      cpl_valid_out <= 1'b0;
    end else begin
      cpl_valid_out <= (wait_q == 4'h1);
      if (tlp_valid_in && !tlp_wr_in) begin
        wait_q      <= slow_in ? 4'h6 : 4'h1;
        data_q      <= tlp_addr_in[31:0] ^ 32'h5A5A_5A5A;
        cpl_src_out <= tlp_src_in;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
